// >>> verilog/uds_status_pins.sv
// status, dma handshake, interrupt and serial pin logic of a quad uart
// Overview of operation
// - force select high drives all interrupt pins in strobe mode
// - force select low lets enable bit decide in strobe mode
// - transmit ready pin shows status or request
// - receive ready pin shows status or request
// - combined transmit ready from four channels
// - snapshot select puts status byte on bus
// - terminal count pulse ends dma transfer
// - grant low with qualifier high starts cycle
// - dma cycle routes access to fifos
// - transmit request high until count or trigger
// - transmit request enabled by mode bit two
// - receive request high until count or empty
// - receive request enabled by mode bit three
// - standard transmit idles and resets high
// - infrared select encodes, transmit idles low
// - infrared output always encoded, idles low
// - infrared receive optionally inverted before decoder
// - clear-to-send drives auto flow and interrupt
// - bus style high selects strobe mode
// - strobe mode interrupt driven per enable bit or force select
`timescale 1ns/1ps
`default_nettype none
`include "uds_regs.svh"
module uds_status_pins (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // register images and core status
    input  wire uds_pkg::uds_cfg_type    cfg [4],
    input  wire uds_pkg::uds_stat_type   stat [4],
    // host bus pins
    input  wire logic                    bus_style_sel,
    input  wire logic                    irq_force_select,
    input  wire logic                    fifo_snapshot_select_n,
    input  wire logic                    transfer_done_pulse,
    input  wire logic                    addr_valid_qualifier,
    input  wire logic [3:0]              transfer_grant_n,
    // serial pins
    input  wire logic [3:0]              rx_in,
    input  wire logic [3:0]              cts_n,
    // status and request pins
    output logic [3:0]                   tx_ready_n,
    output logic [3:0]                   rx_ready_n,
    output logic                         tx_ready_all_n,
    output logic                         rx_ready_all_n,
    // data bus and dma routing
    output logic [7:0]                   data_out,
    output logic                         data_oe,
    output logic [3:0]                   dma_route,
    // interrupt pins
    output logic [3:0]                   irq_out,
    output logic [3:0]                   irq_oe,
    // serial outputs and core side
    output logic [3:0]                   tx_out,
    output logic [3:0]                   infrared_tx_out,
    output logic [3:0]                   rx_to_core,
    output logic [3:0]                   tx_hold,
    output logic [3:0]                   cts_irq
);
    uds_pkg::uds_state_type s_q;
    uds_pkg::uds_state_type s_d;

    ////////////////////////////////////////////////////////////////////////
    // next request state of one channel
    function automatic uds_pkg::uds_drq_type drq_next(
        input uds_pkg::uds_drq_type cur,
        input logic                 en,
        input logic                 want,
        input logic                 stop,
        input logic                 done
    );
        drq_next = cur;
        if (!en) begin
            drq_next = uds_pkg::UDS_IDLE;
        end else begin
            unique case (cur)
                uds_pkg::UDS_IDLE: begin
                    // count pulse beats a fresh request
                    if (want && !stop) begin
                        drq_next = done ? uds_pkg::UDS_HALT : uds_pkg::UDS_REQ;
                    end
                end
                uds_pkg::UDS_REQ: begin
                    if (done) begin
                        drq_next = uds_pkg::UDS_HALT;
                    end else if (stop) begin
                        drq_next = uds_pkg::UDS_IDLE;
                    end
                end
                uds_pkg::UDS_HALT: begin
                    if (stop) begin
                        drq_next = uds_pkg::UDS_IDLE;
                    end
                end
                default: drq_next = uds_pkg::UDS_IDLE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic tx_en;
        logic rx_en;
        logic ir_sel;
        tx_en = 1'h0;
        rx_en = 1'h0;
        ir_sel = 1'h0;
        s_d = s_q;
        for (int c = 0; c < `UDS_CHANNELS; c++) begin
            tx_en = cfg[c].ext_mode_reg[`UDS_XMODE_TX_DMA];
            rx_en = cfg[c].ext_mode_reg[`UDS_XMODE_RX_DMA];
            ir_sel = cfg[c].line_control_word[`UDS_LCW_IR_SEL];
            s_d.tx_drq[c] = drq_next(s_q.tx_drq[c], tx_en, !stat[c].tx_above_trig,
                                     stat[c].tx_above_trig, transfer_done_pulse);
            s_d.rx_drq[c] = drq_next(s_q.rx_drq[c], rx_en, !stat[c].rx_empty,
                                     stat[c].rx_empty, transfer_done_pulse);
            s_d.tx_ready_n[c] = tx_en ? (s_d.tx_drq[c] == uds_pkg::UDS_REQ)
                                      : !stat[c].tx_ready;
            s_d.rx_ready_n[c] = rx_en ? (s_d.rx_drq[c] == uds_pkg::UDS_REQ)
                                      : !stat[c].rx_ready;
            s_d.dma_route[c] = !transfer_grant_n[c] && addr_valid_qualifier;
            if (bus_style_sel) begin
                s_d.irq_out[c] = stat[c].irq;
                s_d.irq_oe[c] = irq_force_select
                                || cfg[c].line_control_word[`UDS_LCW_IRQ_EN];
            end else begin
                s_d.irq_out[c] = 1'h0;
                s_d.irq_oe[c] = (c != 0);
            end
            s_d.tx_out[c] = ir_sel ? stat[c].ir_tx : stat[c].std_tx;
            s_d.infrared_tx_out[c] = stat[c].ir_tx;
            s_d.rx_to_core[c] = ir_sel
                ? (rx_in[c] ^ cfg[c].feature_ctl_reg[`UDS_FEAT_IR_INV])
                : rx_in[c];
            s_d.cts_n_q[c] = cts_n[c];
            s_d.tx_hold[c] = cfg[c].extra_feature_reg[`UDS_XFEAT_AUTO_CTS] && cts_n[c];
            s_d.cts_irq[c] = cfg[c].irq_enable_reg[`UDS_IRQEN_CTS]
                             && (cts_n[c] != s_q.cts_n_q[c]);
        end
        // combined device interrupt, open drain, in rw-line mode
        if (!bus_style_sel) begin
            s_d.irq_oe[0] = stat[0].irq || stat[1].irq || stat[2].irq || stat[3].irq;
        end
        s_d.tx_ready_all_n = &s_d.tx_ready_n;
        s_d.rx_ready_all_n = &s_d.rx_ready_n;
        s_d.data_oe = !fifo_snapshot_select_n;
        s_d.data_out = fifo_snapshot_select_n ? `UDS_SNAP_RST
                                              : {s_d.rx_ready_n, ~s_d.tx_ready_n};
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.tx_ready_n <= 4'hF;
            s_q.rx_ready_n <= 4'hF;
            s_q.tx_ready_all_n <= 1'h1;
            s_q.rx_ready_all_n <= 1'h1;
            s_q.data_out <= `UDS_SNAP_RST;
            s_q.tx_out <= {4{`UDS_TX_IDLE_RST}};
            s_q.infrared_tx_out <= {4{`UDS_INFRARED_TX_OUT_IDLE_RST}};
            s_q.rx_to_core <= 4'hF;
            s_q.cts_n_q <= 4'hF;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_ready_n      = s_q.tx_ready_n;
    assign rx_ready_n      = s_q.rx_ready_n;
    assign tx_ready_all_n  = s_q.tx_ready_all_n;
    assign rx_ready_all_n  = s_q.rx_ready_all_n;
    assign data_out        = s_q.data_out;
    assign data_oe         = s_q.data_oe;
    assign dma_route       = s_q.dma_route;
    assign irq_out         = s_q.irq_out;
    assign irq_oe          = s_q.irq_oe;
    assign tx_out          = s_q.tx_out;
    assign infrared_tx_out = s_q.infrared_tx_out;
    assign rx_to_core      = s_q.rx_to_core;
    assign tx_hold         = s_q.tx_hold;
    assign cts_irq         = s_q.cts_irq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_force_irq_on: assert property (bus_style_sel && irq_force_select |=> &irq_oe)
        else $error("interrupt pins not all driven under force");
    a_enable_bit_off: assert property (
        bus_style_sel && !irq_force_select
        && !cfg[1].line_control_word[`UDS_LCW_IRQ_EN] |=> !irq_oe[1])
        else $error("interrupt pin driven with enable bit clear");
    a_enable_bit_on: assert property (
        bus_style_sel && cfg[2].line_control_word[`UDS_LCW_IRQ_EN]
        |=> irq_oe[2] && irq_out[2] == $past(stat[2].irq))
        else $error("interrupt pin not driven with enable bit set");
    a_rw_irq_low: assert property (
        !bus_style_sel |=> irq_out == 4'h0 && irq_oe[3:1] == 3'h7)
        else $error("unused interrupt pins not driven low in rw-line mode");
    a_rw_irq_any: assert property (
        !bus_style_sel |=> irq_oe[0] == ($past(stat[0].irq) || $past(stat[1].irq)
        || $past(stat[2].irq) || $past(stat[3].irq)))
        else $error("device interrupt not combined in rw-line mode");
    a_tx_status_pin: assert property (
        !cfg[0].ext_mode_reg[`UDS_XMODE_TX_DMA]
        |=> tx_ready_n[0] == !$past(stat[0].tx_ready))
        else $error("transmit ready pin wrong");
    a_rx_status_pin: assert property (
        !cfg[3].ext_mode_reg[`UDS_XMODE_RX_DMA]
        |=> rx_ready_n[3] == !$past(stat[3].rx_ready))
        else $error("receive ready pin wrong");
    a_tx_combined: assert property (tx_ready_all_n == &tx_ready_n)
        else $error("combined transmit ready wrong");
    a_rx_combined: assert property (rx_ready_all_n == &rx_ready_n)
        else $error("combined receive ready wrong");
    a_snapshot_byte: assert property (
        !fifo_snapshot_select_n |=> data_oe && data_out == {rx_ready_n, ~tx_ready_n})
        else $error("snapshot byte wrong");
    a_count_ends_tx: assert property (
        cfg[0].ext_mode_reg[`UDS_XMODE_TX_DMA] && transfer_done_pulse |=> !tx_ready_n[0])
        else $error("terminal count did not drop transmit request");
    a_count_ends_rx: assert property (
        cfg[3].ext_mode_reg[`UDS_XMODE_RX_DMA] && transfer_done_pulse |=> !rx_ready_n[3])
        else $error("terminal count did not drop receive request");
    a_grant_route: assert property (
        !transfer_grant_n[1] && addr_valid_qualifier |=> dma_route[1])
        else $error("dma cycle not started");
    a_no_route: assert property (addr_valid_qualifier == 1'h0 |=> dma_route == 4'h0)
        else $error("dma route without qualifier");
    a_own_grant: assert property (transfer_grant_n[2] |=> !dma_route[2])
        else $error("dma route without own grant");
    a_tx_req_sets: assert property (
        cfg[2].ext_mode_reg[`UDS_XMODE_TX_DMA] && !stat[2].tx_above_trig
        && !transfer_done_pulse && tx_ready_n[2]
        ##1 cfg[2].ext_mode_reg[`UDS_XMODE_TX_DMA] && !stat[2].tx_above_trig
        && !transfer_done_pulse |=> tx_ready_n[2])
        else $error("transmit request dropped early");
    a_rx_req_sets: assert property (
        cfg[1].ext_mode_reg[`UDS_XMODE_RX_DMA] && !stat[1].rx_empty
        && !transfer_done_pulse && rx_ready_n[1]
        ##1 cfg[1].ext_mode_reg[`UDS_XMODE_RX_DMA] && !stat[1].rx_empty
        && !transfer_done_pulse |=> rx_ready_n[1])
        else $error("receive request dropped early");
    a_tx_req_off: assert property (
        !cfg[1].ext_mode_reg[`UDS_XMODE_TX_DMA] |=> s_q.tx_drq[1] == uds_pkg::UDS_IDLE)
        else $error("transmit request while disabled");
    a_rx_empty_drop: assert property (
        cfg[0].ext_mode_reg[`UDS_XMODE_RX_DMA]
        && stat[0].rx_empty |=> !rx_ready_n[0])
        else $error("receive request held with empty fifo");
    a_rx_req_off: assert property (
        !cfg[2].ext_mode_reg[`UDS_XMODE_RX_DMA] |=> s_q.rx_drq[2] == uds_pkg::UDS_IDLE)
        else $error("receive request while disabled");
    a_tx_std_pin: assert property (
        !cfg[0].line_control_word[`UDS_LCW_IR_SEL]
        |=> tx_out[0] == $past(stat[0].std_tx))
        else $error("standard transmit pin wrong");
    a_tx_ir_pin: assert property (
        cfg[3].line_control_word[`UDS_LCW_IR_SEL]
        |=> tx_out[3] == $past(stat[3].ir_tx))
        else $error("infrared transmit pin wrong");
    a_infrared_pin: assert property (##1 infrared_tx_out[1] == $past(stat[1].ir_tx))
        else $error("infrared output not encoded data");
    a_ir_invert: assert property (
        cfg[2].line_control_word[`UDS_LCW_IR_SEL] |=> rx_to_core[2]
        == ($past(rx_in[2]) ^ $past(cfg[2].feature_ctl_reg[`UDS_FEAT_IR_INV])))
        else $error("infrared receive polarity wrong");
    a_ir_plain: assert property (
        !cfg[1].line_control_word[`UDS_LCW_IR_SEL] |=> rx_to_core[1] == $past(rx_in[1]))
        else $error("standard receive path altered");
    a_cts_hold: assert property (
        cfg[0].extra_feature_reg[`UDS_XFEAT_AUTO_CTS] && cts_n[0] |=> tx_hold[0])
        else $error("auto cts did not hold transmitter");
    a_cts_free: assert property (
        !cfg[3].extra_feature_reg[`UDS_XFEAT_AUTO_CTS] |=> !tx_hold[3])
        else $error("transmitter held with auto cts off");
    a_cts_edge: assert property (
        cfg[1].irq_enable_reg[`UDS_IRQEN_CTS] && cts_n[1] != $past(cts_n[1])
        |=> cts_irq[1])
        else $error("clear-to-send change not flagged");

    c_tx_dma_done: cover property (tx_ready_n[0] ##[1:20] transfer_done_pulse);
    c_rx_dma: cover property (rx_ready_n[1] && cfg[1].ext_mode_reg[`UDS_XMODE_RX_DMA]);
    c_snapshot: cover property (data_oe);
    c_forced_irq: cover property (irq_force_select && bus_style_sel);
    c_rw_irq: cover property (!bus_style_sel && irq_oe[0]);
endmodule
`default_nettype wire

// >>> inc/uds_regs.svh
// bit positions, reset values and snapshot layout of the status-pin block
`ifndef UDS_REGS_SVH
`define UDS_REGS_SVH
`define UDS_CHANNELS      4
`define UDS_LCW_IRQ_EN     3
`define UDS_LCW_IR_SEL     6
`define UDS_XMODE_TX_DMA   2
`define UDS_XMODE_RX_DMA   3
`define UDS_FEAT_IR_INV    2
`define UDS_XFEAT_AUTO_CTS 7
`define UDS_IRQEN_CTS      7
`define UDS_SNAP_TX_LSB   0
`define UDS_SNAP_RX_LSB   4
`define UDS_TX_IDLE_RST   1'h1
`define UDS_INFRARED_TX_OUT_IDLE_RST 1'h0
`define UDS_SNAP_RST      8'h00
`endif

// >>> inc/uds_pkg.sv
// types shared by the status-pin block
package uds_pkg;
    // register images of one channel
    typedef struct packed {
        logic [7:0] line_control_word;
        logic [7:0] ext_mode_reg;
        logic [7:0] feature_ctl_reg;
        logic [7:0] extra_feature_reg;
        logic [7:0] irq_enable_reg;
    } uds_cfg_type;
    // per-channel status from the uart core
    typedef struct packed {
        logic irq;
        logic tx_ready;
        logic rx_ready;
        logic tx_above_trig;
        logic rx_empty;
        logic std_tx;
        logic ir_tx;
    } uds_stat_type;
    // request states, gray along idle -> request -> halted
    typedef enum logic [1:0] {
        UDS_IDLE = 2'h0,
        UDS_REQ  = 2'h1,
        UDS_HALT = 2'h3
    } uds_drq_type;
    typedef struct packed {
        uds_drq_type [3:0] tx_drq;
        uds_drq_type [3:0] rx_drq;
        logic [3:0]        tx_ready_n;
        logic [3:0]        rx_ready_n;
        logic              tx_ready_all_n;
        logic              rx_ready_all_n;
        logic [7:0]        data_out;
        logic              data_oe;
        logic [3:0]        dma_route;
        logic [3:0]        irq_out;
        logic [3:0]        irq_oe;
        logic [3:0]        tx_out;
        logic [3:0]        infrared_tx_out;
        logic [3:0]        rx_to_core;
        logic [3:0]        cts_n_q;
        logic [3:0]        tx_hold;
        logic [3:0]        cts_irq;
    } uds_state_type;
endpackage

// >>> dv/uds_serial_partner.sv
// serial line and flow-control partner model of the status-pin block
`timescale 1ns/1ps
`default_nettype none
module uds_serial_partner (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // commands from the bench
    input  wire logic       frame_go,
    input  wire logic [7:0] frame_byte,
    input  wire logic [3:0] cts_want_n,
    input  wire logic       slow,
    // line pins
    output logic [3:0]      rx_in,
    output logic [3:0]      cts_n
);
    logic [9:0] shf_q;
    logic [3:0] cts_dly_q;
    ////////////////////////////////////////////////////////////////////////////
    // line idles high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shf_q     <= 10'h3FF;
            cts_dly_q <= 4'hF;
            cts_n     <= 4'hF;
        end else begin
            shf_q     <= frame_go ? {1'h1, frame_byte, 1'h0} : {1'h1, shf_q[9:1]};
            cts_dly_q <= cts_want_n;
            cts_n     <= slow ? cts_dly_q : cts_want_n;
        end
    end
    assign rx_in = {4{shf_q[0]}};
endmodule
`default_nettype wire

// >>> dv/uds_testbench.sv
// self-checking bench of the status-pin block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        int         due;
        logic [3:0] txn, rxn, rte, iout, ioe, imsk, txo, irp, rxc, hold, ctsi;
        logic [1:0] alln;
        logic [7:0] dat;
        logic       doe;
    } uds_tb_exp_type;
    typedef struct packed {
        uds_pkg::uds_cfg_type  [3:0] cfg;
        uds_pkg::uds_stat_type [3:0] stat;
        logic                        bsel, frc, snap_n, cnt_end, qual, go, slow;
        logic [3:0]                  gnt_n, cts_w;
        logic [7:0]                  fbyte;
    } uds_tb_drv_type;
    logic                  clk = 1'h0;
    logic                  reset_n = 1'h0;
    uds_tb_drv_type        drv, nd;
    uds_pkg::uds_cfg_type  cfg [4];
    uds_pkg::uds_stat_type stat [4];
    uds_pkg::uds_drq_type  tx_st [4], rx_st [4];
    logic [3:0]            tx_ready_n, rx_ready_n, dma_route, irq_out, irq_oe, tx_out;
    logic [3:0]            infrared_tx_out, rx_to_core, tx_hold, cts_irq, rx_in, cts_n;
    logic [3:0]            prev_cts = 4'hF;
    logic                  tx_ready_all_n, rx_ready_all_n, data_oe;
    logic [7:0]            data_out;
    logic [15:0]           r = 16'h9423;
    uds_tb_exp_type        exp_q [$];
    int                    cyc = 0, err_total = 0, check_count = 0;
    initial forever #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always_comb for (int i = 0; i < 4; i++) begin
        cfg[i]  = drv.cfg[i];
        stat[i] = drv.stat[i];
    end
    uds_status_pins DUT (.clk(clk), .reset_n(reset_n), .cfg(cfg), .stat(stat),
        .bus_style_sel(drv.bsel), .irq_force_select(drv.frc),
        .fifo_snapshot_select_n(drv.snap_n), .transfer_done_pulse(drv.cnt_end),
        .addr_valid_qualifier(drv.qual), .transfer_grant_n(drv.gnt_n), .rx_in(rx_in),
        .cts_n(cts_n), .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n),
        .tx_ready_all_n(tx_ready_all_n), .rx_ready_all_n(rx_ready_all_n),
        .data_out(data_out), .data_oe(data_oe), .dma_route(dma_route), .irq_out(irq_out),
        .irq_oe(irq_oe), .tx_out(tx_out), .infrared_tx_out(infrared_tx_out),
        .rx_to_core(rx_to_core), .tx_hold(tx_hold), .cts_irq(cts_irq));
    uds_serial_partner line_model (.clk(clk), .reset_n(reset_n), .frame_go(drv.go),
        .frame_byte(drv.fbyte), .cts_want_n(drv.cts_w), .slow(drv.slow),
        .rx_in(rx_in), .cts_n(cts_n));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // terminal count halts a live or fresh request until the fifo limit
    function automatic uds_pkg::uds_drq_type nxt(uds_pkg::uds_drq_type s, logic en,
                                                 logic want, logic t);
        if (!en) return uds_pkg::UDS_IDLE;
        if (t && s == uds_pkg::UDS_REQ) return uds_pkg::UDS_HALT;
        if (!want) return uds_pkg::UDS_IDLE;
        if (t || s == uds_pkg::UDS_HALT) return uds_pkg::UDS_HALT;
        return uds_pkg::UDS_REQ;
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] expv, string what);
        check_count++;
        if (seen !== expv) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expv);
        end
    endtask
    task automatic tally_and_finish();
        if (exp_q.size() != 0) err_total++;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // drive one cycle and note what the next edge must produce
    task automatic step();
        uds_tb_exp_type e;
        logic           ir, en, any;
        @(posedge clk);
        drv <= nd;
        #1;
        e = '0;
        any = 1'h0;
        e.due = cyc + 1;
        for (int i = 0; i < 4; i++) begin
            ir = drv.cfg[i].line_control_word[6];
            en = drv.cfg[i].ext_mode_reg[2];
            tx_st[i] = nxt(tx_st[i], en, !drv.stat[i].tx_above_trig, drv.cnt_end);
            e.txn[i] = en ? tx_st[i] == uds_pkg::UDS_REQ : !drv.stat[i].tx_ready;
            en = drv.cfg[i].ext_mode_reg[3];
            rx_st[i] = nxt(rx_st[i], en, !drv.stat[i].rx_empty, drv.cnt_end);
            e.rxn[i] = en ? rx_st[i] == uds_pkg::UDS_REQ : !drv.stat[i].rx_ready;
            e.rte[i] = !drv.gnt_n[i] && drv.qual;
            e.iout[i] = drv.bsel && drv.stat[i].irq;
            e.ioe[i] = drv.frc || drv.cfg[i].line_control_word[3];
            any = any | drv.stat[i].irq;
            e.txo[i] = ir ? drv.stat[i].ir_tx : drv.stat[i].std_tx;
            e.irp[i] = drv.stat[i].ir_tx;
            e.rxc[i] = rx_in[i] ^ (ir && drv.cfg[i].feature_ctl_reg[2]);
            e.hold[i] = drv.cfg[i].extra_feature_reg[7] && cts_n[i];
            e.ctsi[i] = drv.cfg[i].irq_enable_reg[7] && (cts_n[i] != prev_cts[i]);
        end
        prev_cts = cts_n;
        if (!drv.bsel) e.ioe = {3'h7, any};
        e.imsk = 4'hF;
        e.alln = {&e.txn, &e.rxn};
        e.doe = !drv.snap_n;
        e.dat = e.doe ? {e.rxn, ~e.txn} : 8'h00;
        exp_q.push_back(e);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        uds_tb_exp_type e;
        forever begin
            @(negedge clk);
            if (exp_q.size() > 0 && exp_q[0].due == cyc) begin
                e = exp_q.pop_front();
                check(32'(tx_ready_n), 32'(e.txn), "tx ready pins");
                check(32'(rx_ready_n), 32'(e.rxn), "rx ready pins");
                check(32'({tx_ready_all_n, rx_ready_all_n}), 32'(e.alln), "combined");
                check(32'({data_oe, data_out}), 32'({e.doe, e.dat}), "snapshot");
                check(32'(dma_route), 32'(e.rte), "dma route");
                check(32'({irq_out, irq_oe & e.imsk}), 32'({e.iout, e.ioe & e.imsk}),
                      "irq pins");
                check(32'(tx_out), 32'(e.txo), "tx line");
                check(32'(infrared_tx_out), 32'(e.irp), "infrared line");
                check(32'(rx_to_core), 32'(e.rxc), "rx path");
                check(32'({tx_hold, cts_irq}), 32'({e.hold, e.ctsi}), "cts");
            end
        end
    end
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        nd = '0;
        nd.bsel = 1'h1;
        nd.snap_n = 1'h1;
        nd.gnt_n = 4'hF;
        nd.cts_w = 4'hF;
        drv = nd;
        for (int i = 0; i < 4; i++) begin
            tx_st[i] = uds_pkg::UDS_IDLE;
            rx_st[i] = uds_pkg::UDS_IDLE;
        end
        repeat (12) @(posedge clk);
        @(negedge clk);
        check(32'({tx_ready_n, rx_ready_n, tx_ready_all_n, rx_ready_all_n, tx_out,
                   infrared_tx_out, rx_to_core}), 32'h003FFF0F, "reset a");
        check(32'({data_out, data_oe, dma_route, irq_oe, irq_out, tx_hold, cts_irq}),
              32'h0, "reset b");
        @(posedge clk);
        reset_n <= 1'h1;
        for (int n = 0; n < 400; n++) begin
            for (int i = 0; i < 4; i++) begin
                r = lfsr(r);
                nd.stat[i] = r[6:0];
                nd.cfg[i][39:24] = r;
                r = lfsr(r);
                nd.cfg[i][23:8] = r;
                nd.cfg[i][7:0] = r[15:8];
            end
            r = lfsr(r);
            nd.bsel = r[0];
            nd.frc = r[0] & r[1];
            nd.snap_n = r[2];
            nd.qual = r[3];
            nd.gnt_n = r[7:4];
            nd.cts_w = r[11:8];
            nd.go = &r[14:12];
            nd.slow = r[15];
            nd.fbyte = r[10:3];
            step();
        end
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 4; i++) begin
                nd.cfg[i].ext_mode_reg = 8'h0C;
                nd.stat[i].tx_above_trig = 1'h0;
                nd.stat[i].rx_empty = 1'h0;
            end
            repeat (k + 2) step();
            // terminal count pulse, fifo not past limit
            nd.cnt_end = 1'h1;
            step();
            nd.cnt_end = 1'h0;
            repeat (3) step();
            for (int i = 0; i < 4; i++) begin
                nd.stat[i].tx_above_trig = 1'h1;
                nd.stat[i].rx_empty = 1'h1;
            end
            repeat (2) step();
        end
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
